// ==== design/sync_serial_pkg.sv ====
// Purpose: Shared constants for the synchronous serial channel.
// Assumes: 32-bit AHB-Lite register bus, one channel.
// Notes:   Offsets are byte addresses; each register is one word.
package sync_serial_pkg;
    // ****************************************
    // Register map
    // ****************************************
    localparam int ADDR_W = 6;
    localparam logic [5:0] OFF_DATA = 6'h00;
    localparam logic [5:0] OFF_STAT = 6'h04;
    localparam logic [5:0] OFF_CLR = 6'h08;
    localparam logic [5:0] OFF_MODE = 6'h0C;
    localparam logic [5:0] OFF_PRES = 6'h10;
    localparam logic [5:0] OFF_STOP = 6'h14;
    localparam logic [5:0] OFF_ISTAT = 6'h18;
    localparam logic [5:0] OFF_ICLR = 6'h1C;
    localparam logic [5:0] OFF_IEN = 6'h20;
    // ****************************************
    // Field positions
    // ****************************************
    localparam int DATA_W = 8;
    localparam int DIV_LSB = 9;
    localparam int DIV_W = 7;
    localparam int MODE_CKS_BIT = 15;
    localparam int MODE_INTSEL_BIT = 0;
    localparam int MODE_MASTER_BIT = 1;
    localparam int MODE_RUN_BIT = 2;
    localparam int STAT_OVF_BIT = 0;
    localparam int STAT_BFF_BIT = 5;
    localparam int STAT_BUSY_BIT = 6;
    localparam int IRQ_CHAN_BIT = 0;
    localparam int IRQ_OVF_BIT = 1;
    localparam int STOP_CH_BIT = 0;
    // ****************************************
    // Reset values and counts
    // ****************************************
    localparam logic [15:0] MODE_RST = 16'h0000;
    localparam logic [7:0] PRES_RST = 8'h00;
    localparam logic [6:0] DIV_RST = 7'h00;
    localparam logic [2:0] LAST_BIT = 3'h7;
    localparam int PRE_CNT_W = 15;
    localparam int SLAVE_MIN_DIV = 6;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
endpackage

// ==== design/prescale_tick.sv ====
// Purpose: Operating-clock enable pulse from the system clock.
// Assumes: Nibble k selects one pulse every 2**k clocks.
// Notes:   A free counter, so changing k never stalls the pulse.
`timescale 1ns/1ps
`default_nettype none
module prescale_tick #(
    parameter int CNT_W = sync_serial_pkg::PRE_CNT_W
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Control
    input wire logic [3:0] power,
    // Pulse
    output logic tick
);
    import sync_serial_pkg::*;

    logic [CNT_W-1:0] cntR;
    logic [CNT_W-1:0] cntNxt;
    logic tickR;
    logic tickNxt;
    logic [CNT_W-1:0] mask;

    always_comb begin
        mask = CNT_W'((32'h1 << power) - 32'h1);
        cntNxt = cntR + CNT_W'(1);
        tickNxt = ((cntNxt & mask) == mask);
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            cntR <= '0;
            tickR <= 1'b0;
        end else begin
            cntR <= cntNxt;
            tickR <= tickNxt;
        end
    end

    assign tick = tickR;

    property p_tick_period;
        @(posedge mclk) disable iff (rst)
        (tickR && $stable(power)) |-> ((cntR & mask) == mask);
    endproperty
    a_tick_period: assert property (p_tick_period) else $error("prescaler pulse off its period");
endmodule
`default_nettype wire

// ==== design/sync_serial_channel.sv ====
// Purpose: One synchronous 3-wire serial channel with AHB-Lite registers.
// Assumes: sclkIn and sdi are synchronous to mclk; clock idles high.
// Notes:   Eight-bit words, MSB first, shift on fall, sample on rise.
//
// Local design decisions: register access over AHB-Lite and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module sync_serial_channel (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [sync_serial_pkg::ADDR_W-1:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Serial link
    input wire logic sclkIn,
    input wire logic sdi,
    output logic sclkOut,
    output logic sclkOeN,
    output logic sdo,
    // Interrupt
    output logic irq
);
    import sync_serial_pkg::*;

    logic [15:0] modeR, modeNxt;
    logic [7:0] presR, presNxt;
    logic [DIV_W-1:0] divR, divNxt;
    logic [DATA_W-1:0] dataR, dataNxt, shR, shNxt, rxShR, rxShNxt;
    logic txFullR, txFullNxt, rxFullR, rxFullNxt, ovfR, ovfNxt, busyR, busyNxt;
    logic [2:0] bitCntR, bitCntNxt;
    logic [1:0] irqStatR, irqStatNxt, irqEnR, irqEnNxt;
    logic irqR, irqNxt, sdoR, sdoNxt, oeNR, oeNNxt;
    logic sclkR, sclkNxt, prevR, prevNxt;
    logic [DIV_W-1:0] halfR, halfNxt;
    logic wPendR, wPendNxt;
    logic [ADDR_W-1:0] wAddrR, wAddrNxt;
    logic [31:0] rdR, rdNxt;
    logic tick, rise, fall, accept, isMaster;
    logic rxDone, bufEmptyEvt, chanEvt, dataRead, dataWrite, clrWrite;

    // ****************************************
    // Operating clock
    // ****************************************
    prescale_tick #(.CNT_W(PRE_CNT_W)) u_pre (
        .mclk(mclk),
        .rst(rst),
        .power(modeR[MODE_CKS_BIT] ? presR[7:4] : presR[3:0]),
        .tick(tick)
    );

    assign isMaster = modeR[MODE_MASTER_BIT];
    assign accept = hsel && htrans[1] && hready;
    assign dataRead = accept && !hwrite && (haddr == OFF_DATA);
    assign dataWrite = wPendR && (wAddrR == OFF_DATA);
    assign clrWrite = wPendR && (wAddrR == OFF_CLR);

    // ****************************************
    // Serial clock edges
    // ****************************************
    // The slave clock is looked at only on operating-clock pulses, so a
    // master faster than opclk/6 gives lost edges rather than glitches.
    always_comb begin
        rise = 1'b0;
        fall = 1'b0;
        halfNxt = halfR;
        sclkNxt = sclkR;
        prevNxt = prevR;
        if (tick) begin
            prevNxt = sclkIn;
            if (busyR && isMaster) begin
                if (halfR == divR) begin
                    halfNxt = '0;
                    sclkNxt = ~sclkR;
                    rise = ~sclkR;
                    fall = sclkR;
                end else begin
                    halfNxt = halfR + DIV_W'(1);
                end
            end else if (busyR) begin
                rise = sclkIn && !prevR;
                fall = !sclkIn && prevR;
            end
        end
        if (!busyR) begin
            sclkNxt = 1'b1;
            halfNxt = '0;
        end
    end

    // ****************************************
    // Shift engine, flags and registers
    // ****************************************
    always_comb begin
        modeNxt = modeR;
        presNxt = presR;
        divNxt = divR;
        dataNxt = dataR;
        shNxt = shR;
        rxShNxt = rxShR;
        txFullNxt = txFullR;
        rxFullNxt = rxFullR;
        ovfNxt = ovfR;
        busyNxt = busyR;
        bitCntNxt = bitCntR;
        irqEnNxt = irqEnR;
        rxDone = 1'b0;
        bufEmptyEvt = 1'b0;
        if (busyR && rise) begin
            rxShNxt = {rxShR[DATA_W-2:0], sdi};
            bitCntNxt = bitCntR + 3'h1;
            if (bitCntR == LAST_BIT) begin
                rxDone = 1'b1;
                busyNxt = 1'b0;
                // Pending byte goes to the shifter before the received byte
                // takes the shared buffer, else continuous mode loses it
                if (txFullR && modeR[MODE_RUN_BIT]) begin
                    shNxt = dataR;
                    txFullNxt = 1'b0;
                    busyNxt = 1'b1;
                    bufEmptyEvt = 1'b1;
                end
                dataNxt = {rxShR[DATA_W-2:0], sdi};
                rxFullNxt = 1'b1;
            end
        end else if (busyR && fall && bitCntR != 3'h0) begin
            shNxt = {shR[DATA_W-2:0], 1'b0};
        end else if (!busyR && txFullR && modeR[MODE_RUN_BIT]) begin
            shNxt = dataR;
            txFullNxt = 1'b0;
            busyNxt = 1'b1;
            bitCntNxt = 3'h0;
            bufEmptyEvt = 1'b1;
        end
        ovfNxt = (ovfR && !(clrWrite && hwdata[STAT_OVF_BIT])) || (rxDone && rxFullR);
        if (dataRead) begin
            rxFullNxt = rxDone;
        end
        if (wPendR) begin
            unique case (wAddrR)
                OFF_DATA: begin
                    dataNxt = hwdata[DATA_W-1:0];
                    divNxt = hwdata[DIV_LSB+DIV_W-1:DIV_LSB];
                    txFullNxt = 1'b1;
                    rxFullNxt = 1'b0;
                end
                OFF_MODE: modeNxt = hwdata[15:0];
                OFF_PRES: presNxt = hwdata[7:0];
                OFF_STOP: begin
                    if (hwdata[STOP_CH_BIT]) begin
                        modeNxt[MODE_RUN_BIT] = 1'b0;
                    end
                end
                OFF_IEN: irqEnNxt = hwdata[1:0];
                default: ;
            endcase
        end
        if (!modeNxt[MODE_RUN_BIT]) begin
            busyNxt = 1'b0;
        end
    end

    // ****************************************
    // Interrupt, bus answer and pin outputs
    // ****************************************
    always_comb begin
        chanEvt = modeR[MODE_INTSEL_BIT] ? bufEmptyEvt : rxDone;
        irqStatNxt = irqStatR;
        if (wPendR && wAddrR == OFF_ICLR) begin
            irqStatNxt = irqStatR & ~hwdata[1:0];
        end
        irqStatNxt[IRQ_CHAN_BIT] = irqStatNxt[IRQ_CHAN_BIT] | chanEvt;
        irqStatNxt[IRQ_OVF_BIT] = irqStatNxt[IRQ_OVF_BIT] | (rxDone && rxFullR);
        irqNxt = |(irqStatNxt & irqEnNxt);
        wPendNxt = accept && hwrite;
        wAddrNxt = accept ? haddr : wAddrR;
        rdNxt = rdR;
        if (accept && !hwrite) begin
            unique case (haddr)
                OFF_DATA: rdNxt = {16'h0000, divR, 1'b0, dataR};
                OFF_STAT: rdNxt = {25'h0, busyR, txFullR || rxFullR, 4'h0, ovfR};
                OFF_MODE: rdNxt = {16'h0000, modeR};
                OFF_PRES: rdNxt = {24'h000000, presR};
                OFF_ISTAT: rdNxt = {30'h0, irqStatR};
                OFF_IEN: rdNxt = {30'h0, irqEnR};
                default: rdNxt = 32'h00000000;
            endcase
        end
        sdoNxt = shNxt[DATA_W-1];
        oeNNxt = !modeNxt[MODE_MASTER_BIT];
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            modeR <= MODE_RST;
            presR <= PRES_RST;
            divR <= DIV_RST;
            dataR <= '0;
            shR <= '0;
            rxShR <= '0;
            txFullR <= 1'b0;
            rxFullR <= 1'b0;
            ovfR <= 1'b0;
            busyR <= 1'b0;
            bitCntR <= 3'h0;
            irqStatR <= 2'h0;
            irqEnR <= 2'h0;
            irqR <= 1'b0;
            sdoR <= 1'b0;
            oeNR <= 1'b1;
            sclkR <= 1'b1;
            prevR <= 1'b1;
            halfR <= '0;
            wPendR <= 1'b0;
            wAddrR <= '0;
            rdR <= 32'h00000000;
        end else begin
            modeR <= modeNxt;
            presR <= presNxt;
            divR <= divNxt;
            dataR <= dataNxt;
            shR <= shNxt;
            rxShR <= rxShNxt;
            txFullR <= txFullNxt;
            rxFullR <= rxFullNxt;
            ovfR <= ovfNxt;
            busyR <= busyNxt;
            bitCntR <= bitCntNxt;
            irqStatR <= irqStatNxt;
            irqEnR <= irqEnNxt;
            irqR <= irqNxt;
            sdoR <= sdoNxt;
            oeNR <= oeNNxt;
            sclkR <= sclkNxt;
            prevR <= prevNxt;
            halfR <= halfNxt;
            wPendR <= wPendNxt;
            wAddrR <= wAddrNxt;
            rdR <= rdNxt;
        end
    end

    // Zero-wait slave with fixed OKAY: both are constants after reset
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = rdR;
    assign sclkOut = sclkR;
    assign sclkOeN = oeNR;
    assign sdo = sdoR;
    assign irq = irqR;

    // ****************************************
    // Checks
    // ****************************************
    sequence s_dataWrite;
        wPendR && (wAddrR == OFF_DATA);
    endsequence

    property p_overwrite;
        @(posedge mclk) disable iff (rst)
        s_dataWrite |=> (dataR == $past(hwdata[7:0])) && txFullR;
    endproperty
    a_overwrite: assert property (p_overwrite) else $error("data write did not replace buffer");

    property p_read_keeps_tx;
        @(posedge mclk) disable iff (rst)
        (dataRead && txFullR && busyR && !wPendR && !rxDone) |=> txFullR;
    endproperty
    a_read_keeps_tx: assert property (p_read_keeps_tx) else $error("data read disturbed transmit");

    property p_master_half;
        @(posedge mclk) disable iff (rst)
        (busyR && isMaster && tick && halfR == divR && modeNxt[MODE_RUN_BIT]) |=> (sclkR != $past(sclkR));
    endproperty
    a_master_half: assert property (p_master_half) else $error("master clock did not toggle");

    property p_div_field;
        @(posedge mclk) disable iff (rst)
        s_dataWrite |=> (divR == $past(hwdata[15:9]));
    endproperty
    a_div_field: assert property (p_div_field) else $error("divider field not stored");

    property p_slave_sample;
        @(posedge mclk) disable iff (rst)
        !tick |=> $stable(prevR);
    endproperty
    a_slave_sample: assert property (p_slave_sample) else $error("slave clock sampled off pulse");

    property p_clear_exact;
        @(posedge mclk) disable iff (rst)
        (clrWrite && ovfR && !hwdata[STAT_OVF_BIT]) |=> ovfR;
    endproperty
    a_clear_exact: assert property (p_clear_exact) else $error("unwritten error flag cleared");

    property p_clear_done;
        @(posedge mclk) disable iff (rst)
        (clrWrite && hwdata[STAT_OVF_BIT] && !(rxDone && rxFullR)) |=> !ovfR;
    endproperty
    a_clear_done: assert property (p_clear_done) else $error("written error flag not cleared");

    sequence s_endWord;
        rxDone && !modeR[MODE_INTSEL_BIT] && irqEnR[IRQ_CHAN_BIT] && !wPendR;
    endsequence

    property p_int_select;
        @(posedge mclk) disable iff (rst)
        s_endWord |=> irqStatR[IRQ_CHAN_BIT] ##1 irq;
    endproperty
    a_int_select: assert property (p_int_select) else $error("transfer end interrupt missing");

    property p_overflow;
        @(posedge mclk) disable iff (rst)
        (rxDone && rxFullR) |=> ovfR && irqStatR[IRQ_OVF_BIT];
    endproperty
    a_overflow: assert property (p_overflow) else $error("overflow not flagged");
endmodule
`default_nettype wire

// ==== tb/serial_master_model.sv ====
// Purpose: External master that clocks words into the channel in slave mode.
// Assumes: Clock idles high; data changes on fall and is sampled on rise.
// Notes:   HALF is the half period in mclk cycles; call xfer just after an edge.
`timescale 1ns/1ps
`default_nettype none
module serial_master_model #(
    parameter int HALF = 3
) (
    // Clock
    input wire logic mclk,
    // Serial link
    output logic sclkIn,
    output logic sdi,
    input wire logic sdo
);
    // ****************************************
    // Frame driver
    // ****************************************
    initial begin
        sclkIn = 1'b1;
        sdi = 1'b0;
    end
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            sclkIn <= 1'b0;
            sdi <= tx[i];
            repeat (HALF) @(posedge mclk);
            sclkIn <= 1'b1;
            rx = {rx[6:0], sdo};
            repeat (HALF) @(posedge mclk);
        end
        // Line has no pull, so a stale bit must not look valid
        sdi <= ~tx[0];
    endtask
endmodule
`default_nettype wire

// ==== tb/testbench.sv ====
// Purpose: Register-level tests of the serial channel over AHB-Lite.
// Assumes: Slave tests run with the prescaler at k=0.
// Notes:   Master rates are measured between falls of the serial clock.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin checksDone++; if ((a) !== (e)) begin nMismatch++; \
$display("mismatch t=%0t got=%h exp=%h", $time, (a), (e)); end end
module testbench;
    import sync_serial_pkg::*;
    logic mclk, rst, hsel, hwrite, hready, hreadyout, hresp;
    logic [ADDR_W-1:0] haddr;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] hwdata, hrdata, rd, per, modeV;
    logic sclkIn, sdi, sclkOut, sclkOeN, sdo, irq;
    logic [7:0] rx;
    logic [3:0] k;
    time t0;
    int nMismatch, checksDone;
    logic [7:0] presT [4] = '{8'h00, 8'h31, 8'h20, 8'h00};
    logic cksT [4] = '{1'b0, 1'b0, 1'b1, 1'b0};
    int divT [4] = '{0, 2, 1, 127};
    assign hready = hreadyout;
    always #2.5 mclk = ~mclk;
    sync_serial_channel uut (.mclk(mclk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .sclkIn(sclkIn), .sdi(sdi), .sclkOut(sclkOut),
        .sclkOeN(sclkOeN), .sdo(sdo), .irq(irq));
    serial_master_model #(.HALF(SLAVE_MIN_DIV / 2)) partner (.mclk(mclk), .sclkIn(sclkIn), .sdi(sdi), .sdo(sdo));
    // ****************************************
    // Bus tasks
    // ****************************************
    task automatic busXfer(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d,
        output logic [31:0] r);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= HTRANS_NONSEQ;
        hwrite <= wr;
        do @(posedge mclk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge mclk); while (hready !== 1'b1);
        r = hrdata;
    endtask
    task automatic busWrite(input logic [ADDR_W-1:0] a, input logic [31:0] d);
        logic [31:0] r;
        busXfer(1'b1, a, d, r);
    endtask
    task automatic chkReg(input logic [ADDR_W-1:0] a, input logic [31:0] e);
        logic [31:0] r;
        busXfer(1'b0, a, 32'h0, r);
        `CHK(r, e)
    endtask
    task automatic complete_run();
        if (nMismatch == 0 && checksDone > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // ****************************************
    // Watchdog
    // ****************************************
    initial begin
        repeat (60000) @(posedge mclk);
        nMismatch++;
        complete_run();
    end
    // ****************************************
    // Tests
    // ****************************************
    initial begin
        mclk = 1'b0;
        rst = 1'b1;
        hsel = 1'b0;
        haddr = '0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        repeat (6) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        `CHK({irq, sclkOut, sclkOeN, hresp}, 4'h6)
        chkReg(OFF_MODE, 32'h0);
        chkReg(OFF_STAT, 32'h0);
        busWrite(6'h3C, 32'hFFFFFFFF);
        chkReg(6'h3C, 32'h0);
        // Single mode: pending byte is replaced before the master clocks
        busWrite(OFF_IEN, 32'h3);
        busWrite(OFF_DATA, 32'h11);
        busWrite(OFF_DATA, 32'h22);
        chkReg(OFF_DATA, 32'h22);
        chkReg(OFF_STAT, 32'h20);
        busWrite(OFF_MODE, 32'h1 << MODE_RUN_BIT);
        repeat (2) @(posedge mclk);
        partner.xfer(8'h3C, rx);
        `CHK(rx, 8'h22)
        repeat (4) @(posedge mclk);
        chkReg(OFF_ISTAT, 32'h1);
        `CHK(irq, 1'b1)
        busWrite(OFF_IEN, 32'h0);
        repeat (2) @(posedge mclk);
        `CHK(irq, 1'b0)
        chkReg(OFF_DATA, 32'h3C);
        chkReg(OFF_STAT, 32'h0);
        busWrite(OFF_ICLR, 32'h3);
        chkReg(OFF_ISTAT, 32'h0);
        // Continuous mode with an unread word: overflow and recovery
        busWrite(OFF_MODE, (32'h1 << MODE_RUN_BIT) | (32'h1 << MODE_INTSEL_BIT));
        busWrite(OFF_IEN, 32'h3);
        busWrite(OFF_DATA, 32'hC3);
        busWrite(OFF_DATA, 32'h5A);
        chkReg(OFF_STAT, 32'h60);
        chkReg(OFF_DATA, 32'h5A);
        partner.xfer(8'h81, rx);
        `CHK(rx, 8'hC3)
        repeat (4) @(posedge mclk);
        partner.xfer(8'h7E, rx);
        `CHK(rx, 8'h5A)
        repeat (4) @(posedge mclk);
        chkReg(OFF_STAT, 32'h21);
        chkReg(OFF_ISTAT, 32'h3);
        `CHK(irq, 1'b1)
        chkReg(OFF_DATA, 32'h7E);
        busXfer(1'b0, OFF_STAT, 32'h0, rd);
        `CHK(rd, 32'h1)
        busWrite(OFF_CLR, 32'h0);
        chkReg(OFF_STAT, 32'h1);
        busWrite(OFF_CLR, rd);
        chkReg(OFF_STAT, 32'h0);
        busWrite(OFF_ICLR, 32'h3);
        chkReg(OFF_ISTAT, 32'h0);
        `CHK(irq, 1'b0)
        // Master rates over prescaler source, nibble and divider
        for (int i = 0; i < 4; i++) begin
            k = cksT[i] ? presT[i][7:4] : presT[i][3:0];
            per = 32'(2 * (divT[i] + 1)) << k;
            modeV = (32'(cksT[i]) << MODE_CKS_BIT) | (32'h1 << MODE_MASTER_BIT);
            busWrite(OFF_PRES, {24'h0, presT[i]});
            busWrite(OFF_MODE, modeV | (32'h1 << MODE_RUN_BIT));
            busWrite(OFF_DATA, {16'h0, 7'(divT[i]), 9'h096});
            @(negedge sclkOut);
            t0 = $time;
            @(negedge sclkOut);
            `CHK(32'(($time - t0) / 5), per)
            `CHK(sclkOeN, 1'b0)
            @(posedge mclk);
            busWrite(OFF_STOP, 32'h0000000F);
            repeat (2) @(posedge mclk);
            chkReg(OFF_STAT, 32'h0);
            chkReg(OFF_MODE, modeV);
        end
        complete_run();
    end
endmodule
`default_nettype wire
